// *** hdl/mds_consts.svh ***
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

// Register byte offsets on the APB word map.
`define MDS_CORE_CONTROL_OFF  12'h044
`define MDS_STATUS_OFF        12'h060
`define MDS_RESULT_LO_OFF     12'h064
`define MDS_RESULT_HI_OFF     12'h068
`define MDS_REMAINDER_OFF     12'h06c

// Core control register reset value and writable bits.
`define MDS_CORE_CONTROL_RST  16'h0020
`define MDS_CORE_CONTROL_MASK 16'h1fff

// Unsigned-multiply select bit in core control.
`define MDS_US_BIT            12

// Divide length in instruction cycles, and the steps inside it.
`define MDS_DIV_CYCLES        5'd19
`define MDS_DIV_ITER_LAST     5'd16
`define MDS_DIV_FIX_STEP      5'd17

// Largest shift distance in one cycle.
`define MDS_SHIFT_MAX         5'd16

`endif

// *** hdl/mds_pkg.sv ***
package mds_pkg;

	typedef enum logic [2:0] {
		MDS_OP_NOP     = 3'b000,
		MDS_OP_MUL     = 3'b001,
		MDS_OP_DIV     = 3'b010,
		MDS_OP_DIVSTEP = 3'b011,
		MDS_OP_SHIFT   = 3'b100
	} mds_op_t;

	// Operand signedness: first letter is operand a, second is operand b.
	typedef enum logic [1:0] {
		MDS_SM_SS = 2'b00,
		MDS_SM_UU = 2'b01,
		MDS_SM_SU = 2'b10,
		MDS_SM_US = 2'b11
	} mds_sign_t;

	typedef enum logic {
		MDS_DIV_IDLE = 1'b0,
		MDS_DIV_RUN  = 1'b1
	} mds_div_state_t;

	typedef struct packed {
		mds_op_t   op;
		logic      dsp;
		mds_sign_t sgn;
		logic      frac;
		logic      wide;
		logic      left;
		logic      arith;
		logic [4:0] amt;
	} mds_req_t;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] hi;
		logic [39:0] acc;
	} mds_opnd_t;

endpackage

// *** hdl/mds_datapath.sv ***
// What this block does
// - One single-cycle 17x17 multiplier, shared by integer and DSP operations.
// - Multiplier handles signed, unsigned and mixed operands by 17th-bit extension.
// - Fractional multiply gives exact results, minus one squared without wrap.
// - Divider does 16/16 in fractional and integer formats, and 32/16 in integer format only.
// - Divide runs one step per cycle, nineteen cycles under a repeat loop.
// - Divide may pause at any step; partial quotient and remainder are kept.
// - 40-bit barrel shifter moves left or right up to 16 places in one cycle.
// - Barrel shifter is one resource shared by integer and DSP instructions.
`timescale 1ns/1ps
`default_nettype none
`include "mds_consts.svh"

module mds_datapath
	import mds_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	// Sequencer request port.
	input  wire logic        op_valid_in,
	input  wire mds_req_t    op_req_in,
	input  wire mds_opnd_t   op_opnd_in,
	// Results to the sequencer.
	output logic [39:0]      result_out,
	output logic [15:0]      remainder_out,
	output logic             div_done_out,
	output logic             div_busy_out,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);

	function automatic logic [16:0] ext17(input logic [15:0] v,
		input logic sgn);
		ext17 = {sgn & v[15], v};
	endfunction

	function automatic logic [15:0] neg16(input logic [15:0] v,
		input logic en);
		neg16 = en ? 16'(~v + 16'h0001) : v;
	endfunction

	logic [15:0]    core_control_ff;
	logic [39:0]    result_ff;
	logic [15:0]    remainder_ff;
	logic           div_done_ff;
	mds_div_state_t div_state_ff;
	logic [4:0]     div_cnt_ff;
	logic [16:0]    div_rem_ff;
	logic [15:0]    div_quo_ff;
	logic [15:0]    div_den_ff;
	logic           div_negq_ff;
	logic           div_negr_ff;
	logic [31:0]    prdata_ff;

	logic           issue_mul;
	logic           issue_div;
	logic           issue_step;
	logic           issue_shift;
	mds_sign_t      mul_mode;
	logic           sa;
	logic           sb;
	logic [33:0]    nxt_prod;
	logic [39:0]    nxt_mul_res;
	logic [39:0]    shf_src;
	logic [4:0]     shf_amt;
	logic [39:0]    nxt_shf_res;
	logic [31:0]    dvd;
	logic [31:0]    dvd_mag;
	logic           dvd_neg;
	logic           den_neg;
	logic [16:0]    trial;
	logic [16:0]    trial_sub;
	logic           trial_ok;
	logic           apb_setup;
	logic           apb_wr;
	logic           addr_hit;

	assign issue_mul   = op_valid_in && op_req_in.op == MDS_OP_MUL;
	assign issue_div   = op_valid_in && op_req_in.op == MDS_OP_DIV;
	assign issue_step  = op_valid_in && op_req_in.op == MDS_OP_DIVSTEP
		&& div_state_ff == MDS_DIV_RUN;
	assign issue_shift = op_valid_in && op_req_in.op == MDS_OP_SHIFT;

	// DSP multiplies take their signedness from core control, integer ones
	// from the instruction; both drive the same multiplier below.
	always_comb begin
		mul_mode = op_req_in.sgn;
		if (op_req_in.dsp) begin
			mul_mode = core_control_ff[`MDS_US_BIT] ? MDS_SM_UU : MDS_SM_SS;
		end
	end

	assign sa = mul_mode == MDS_SM_SS || mul_mode == MDS_SM_SU;
	assign sb = mul_mode == MDS_SM_SS || mul_mode == MDS_SM_US;
	assign nxt_prod = 34'($signed(ext17(op_opnd_in.a, sa))
		* $signed(ext17(op_opnd_in.b, sb)));

	// The fractional shift is done in 35 bits so that minus one squared
	// lands as plus one in the 40-bit result instead of wrapping.
	always_comb begin
		if (op_req_in.frac) begin
			nxt_mul_res = {{5{nxt_prod[33]}}, nxt_prod, 1'b0};
		end else begin
			nxt_mul_res = {{6{nxt_prod[33]}}, nxt_prod};
		end
	end

	always_comb begin
		if (op_req_in.dsp) begin
			shf_src = op_opnd_in.acc;
		end else begin
			shf_src = {{24{op_req_in.arith & op_opnd_in.a[15]}},
				op_opnd_in.a};
		end
		shf_amt = (op_req_in.amt > `MDS_SHIFT_MAX) ? `MDS_SHIFT_MAX
			: op_req_in.amt;
		if (op_req_in.left) begin
			nxt_shf_res = shf_src << shf_amt;
		end else if (op_req_in.arith) begin
			nxt_shf_res = 40'($signed(shf_src) >>> shf_amt);
		end else begin
			nxt_shf_res = shf_src >> shf_amt;
		end
	end

	// Divider load: the dividend is formed so that sixteen restoring steps
	// always yield a sixteen-bit quotient.
	always_comb begin
		// A signed fractional dividend keeps its sign above the scaled word,
		// so that negative Q15 operands divide as negative values.
		if (op_req_in.frac) begin
			dvd = {op_req_in.sgn == MDS_SM_SS & op_opnd_in.a[15],
				op_opnd_in.a, 15'h0000};
		end else if (op_req_in.wide) begin
			dvd = {op_opnd_in.hi, op_opnd_in.a};
		end else begin
			dvd = {{16{op_req_in.sgn == MDS_SM_SS & op_opnd_in.a[15]}},
				op_opnd_in.a};
		end
		dvd_neg = op_req_in.sgn == MDS_SM_SS && dvd[31];
		den_neg = op_req_in.sgn == MDS_SM_SS && op_opnd_in.b[15];
		dvd_mag = dvd_neg ? 32'(~dvd + 32'h0000_0001) : dvd;
	end

	assign trial     = {div_rem_ff[15:0], div_quo_ff[15]};
	assign trial_sub = 17'(trial - {1'b0, div_den_ff});
	assign trial_ok  = trial >= {1'b0, div_den_ff};

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			core_control_ff <= `MDS_CORE_CONTROL_RST;
		end else if (apb_wr && paddr_in == `MDS_CORE_CONTROL_OFF) begin
			core_control_ff <= pwdata_in[15:0] & `MDS_CORE_CONTROL_MASK;
		end
	end

	// The divider state only moves on its own steps, so the sequencer may
	// run other work between steps and resume later without loss.
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			div_state_ff <= MDS_DIV_IDLE;
			div_cnt_ff   <= 5'd0;
			div_rem_ff   <= 17'h00000;
			div_quo_ff   <= 16'h0000;
			div_den_ff   <= 16'h0000;
			div_negq_ff  <= 1'b0;
			div_negr_ff  <= 1'b0;
		end else if (issue_div) begin
			div_state_ff <= MDS_DIV_RUN;
			div_cnt_ff   <= 5'd1;
			div_rem_ff   <= {1'b0, dvd_mag[31:16]};
			div_quo_ff   <= dvd_mag[15:0];
			div_den_ff   <= neg16(op_opnd_in.b, den_neg);
			div_negq_ff  <= dvd_neg ^ den_neg;
			div_negr_ff  <= dvd_neg;
		end else if (issue_step) begin
			div_cnt_ff <= 5'(div_cnt_ff + 5'd1);
			if (div_cnt_ff <= `MDS_DIV_ITER_LAST) begin
				div_rem_ff <= trial_ok ? trial_sub : trial;
				div_quo_ff <= {div_quo_ff[14:0], trial_ok};
			end else if (div_cnt_ff == `MDS_DIV_FIX_STEP) begin
				div_quo_ff <= neg16(div_quo_ff, div_negq_ff);
				div_rem_ff <= {1'b0, neg16(div_rem_ff[15:0], div_negr_ff)};
			end else begin
				div_state_ff <= MDS_DIV_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			result_ff    <= 40'h00_0000_0000;
			remainder_ff <= 16'h0000;
			div_done_ff  <= 1'b0;
		end else begin
			div_done_ff <= 1'b0;
			if (issue_mul) begin
				result_ff <= nxt_mul_res;
			end else if (issue_shift) begin
				result_ff <= nxt_shf_res;
			end else if (issue_step
				&& div_cnt_ff == 5'(`MDS_DIV_CYCLES - 5'd1)) begin
				result_ff    <= {{24{div_quo_ff[15]}}, div_quo_ff};
				remainder_ff <= div_rem_ff[15:0];
				div_done_ff  <= 1'b1;
			end
		end
	end

	assign result_out    = result_ff;
	assign remainder_out = remainder_ff;
	assign div_done_out  = div_done_ff;
	assign div_busy_out  = div_state_ff == MDS_DIV_RUN;

	// APB: read data is captured in the setup cycle, so the access phase
	// always completes with no wait states.
	assign apb_setup = psel_in && !penable_in;
	assign apb_wr    = psel_in && penable_in && pwrite_in && addr_hit;

	always_comb begin
		case (paddr_in)
			`MDS_CORE_CONTROL_OFF,
			`MDS_STATUS_OFF,
			`MDS_RESULT_LO_OFF,
			`MDS_RESULT_HI_OFF,
			`MDS_REMAINDER_OFF: addr_hit = 1'b1;
			default:            addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup) begin
			case (paddr_in)
				`MDS_CORE_CONTROL_OFF: prdata_ff <= {16'h0000, core_control_ff};
				`MDS_STATUS_OFF: prdata_ff <= {25'h0000000,
					div_done_ff, div_state_ff == MDS_DIV_RUN, div_cnt_ff};
				`MDS_RESULT_LO_OFF: prdata_ff <= result_ff[31:0];
				`MDS_RESULT_HI_OFF: prdata_ff <= {24'h000000, result_ff[39:32]};
				`MDS_REMAINDER_OFF: prdata_ff <= {16'h0000, remainder_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata_out  = prdata_ff;
	assign pready_out  = psel_in && penable_in;
	assign pslverr_out = psel_in && penable_in && !addr_hit;

endmodule

`default_nettype wire

// *** tb/mds_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module mds_asserts
	import mds_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        nrst_in,
	input wire logic        op_valid_in,
	input wire mds_req_t    op_req_in,
	input wire mds_opnd_t   op_opnd_in,
	input wire logic [39:0] result_out,
	input wire logic [15:0] remainder_out,
	input wire logic        div_done_out,
	input wire logic        div_busy_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	logic        m;
	logic        s;
	logic        v;
	logic [15:0] a;
	logic [15:0] b;
	assign a = op_opnd_in.a;
	assign b = op_opnd_in.b;
	assign m = op_valid_in && op_req_in.op == MDS_OP_MUL && !op_req_in.dsp;
	assign s = op_valid_in && op_req_in.op == MDS_OP_SHIFT
		&& !op_req_in.arith && op_req_in.amt <= 5'h10;
	assign v = op_valid_in && op_req_in.op == MDS_OP_DIVSTEP;
	property p_mu;
		m && op_req_in.sgn == MDS_SM_UU && !op_req_in.frac
			|=> result_out == $past(a) * $past(b);
	endproperty
	a_mu: assert property (p_mu)
		else $error("unsigned product wrong");
	property p_ss;
		m && op_req_in.sgn == MDS_SM_SS && !op_req_in.frac
			|=> $signed(result_out) == $signed($past(a)) * $signed($past(b));
	endproperty
	a_ss: assert property (p_ss)
		else $error("signed product wrong");
	property p_fr;
		m && op_req_in.frac && a == 16'h8000 && b == 16'h8000
			&& op_req_in.sgn == MDS_SM_SS |=> result_out == 40'h0080000000;
	endproperty
	a_fr: assert property (p_fr)
		else $error("fractional corner product wrong");
	property p_sr;
		s && op_req_in.dsp && !op_req_in.left
			|=> result_out == $past(op_opnd_in.acc) >> $past(op_req_in.amt);
	endproperty
	a_sr: assert property (p_sr)
		else $error("wide right shift wrong");
	property p_sl;
		s && !op_req_in.dsp && op_req_in.left
			|=> result_out == {24'h0, $past(a)} << $past(op_req_in.amt);
	endproperty
	a_sl: assert property (p_sl)
		else $error("integer left shift wrong");
	property p_len;
		op_valid_in && op_req_in.op == MDS_OP_DIV ##1 v [*8] ##1 v [*8]
			##1 v [*2] |=> div_done_out && !div_busy_out;
	endproperty
	a_len: assert property (p_len)
		else $error("divide did not finish in time");
	property p_hold;
		div_busy_out && !op_valid_in |=> div_busy_out && !div_done_out;
	endproperty
	a_hold: assert property (p_hold)
		else $error("divide lost state while paused");
	property p_rem;
		!div_done_out && $past(nrst_in) |-> $stable(remainder_out);
	endproperty
	a_rem: assert property (p_rem)
		else $error("remainder moved without completion");
endmodule
bind mds_datapath mds_asserts u_chk (
	.core_clk_in, .nrst_in, .op_valid_in, .op_req_in, .op_opnd_in,
	.result_out, .remainder_out, .div_done_out, .div_busy_out
);
`default_nettype wire

// *** tb/mds_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mds_seq_model
	import mds_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      nrst_in,
	input  wire logic      go_in,
	input  wire logic      pause_in,
	input  wire mds_req_t  req_in,
	input  wire mds_opnd_t opnd_in,
	output var logic       op_valid_out,
	output var mds_req_t   op_req_out,
	output var mds_opnd_t  op_opnd_out,
	output logic           busy_out
);
	logic [4:0] left_ff = 5'h0;
	initial {op_valid_out, op_req_out, op_opnd_out} = '0;
	assign busy_out = left_ff != 5'h0;
	// Idle operands toggle so that a stale value is never mistaken for data.
	always @(posedge clk_in) begin
		op_valid_out <= go_in || busy_out && !pause_in;
		op_opnd_out <= go_in ? opnd_in : ~op_opnd_out;
		if (go_in)
			op_req_out <= req_in;
		else
			op_req_out.op <= MDS_OP_DIVSTEP;
		if (!nrst_in)
			left_ff <= 5'h0;
		else if (go_in)
			left_ff <= req_in.op == MDS_OP_DIV ? 5'h12 : 5'h0;
		else if (busy_out && !pause_in)
			left_ff <= left_ff - 5'h1;
	end
endmodule
`default_nettype wire

// *** tb/mul_div_shift_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mul_div_shift_datapath_tb;
	import mds_pkg::*;
	logic        core_clk_in = 1'b0, nrst_in = 1'b0, go = 1'b0, pause = 1'b0;
	logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic        rndp = 1'b0, us = 1'b0;
	logic [11:0] paddr_in = 12'h0;
	logic [31:0] pwdata_in = 32'h0;
	mds_req_t    rq = '0;
	mds_opnd_t   od = '0;
	logic        op_valid_in, div_done_out, div_busy_out, sbusy;
	logic        pready_out, pslverr_out;
	mds_req_t    op_req_in;
	mds_opnd_t   op_opnd_in;
	logic [39:0] result_out;
	logic [15:0] remainder_out;
	logic [31:0] prdata_out;
	int          failures = 0, compares = 0;
	mds_datapath DUT (
		.core_clk_in, .nrst_in, .op_valid_in, .op_req_in, .op_opnd_in,
		.result_out, .remainder_out, .div_done_out, .div_busy_out,
		.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out
	);
	mds_seq_model u_seq (
		.clk_in(core_clk_in), .nrst_in, .go_in(go), .pause_in(pause),
		.req_in(rq), .opnd_in(od), .op_valid_out(op_valid_in),
		.op_req_out(op_req_in), .op_opnd_out(op_opnd_in), .busy_out(sbusy)
	);
	initial forever #10 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) pause <= rndp & 1'($urandom);
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp)
			$display("FAIL at %0t: seen %h expected %h", $time, got, exp);
		if (got !== exp)
			failures++;
	endtask
	task automatic give_verdict(input int hang);
		failures += hang;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [55:0] expect_of(mds_req_t r, mds_opnd_t o);
		longint x;
		longint y;
		logic [39:0] v;
		x = o.a;
		y = o.b;
		if (r.op == MDS_OP_MUL) begin
			if (r.dsp ? !us : r.sgn inside {MDS_SM_SS, MDS_SM_SU})
				x = $signed(o.a);
			if (r.dsp ? !us : r.sgn inside {MDS_SM_SS, MDS_SM_US})
				y = $signed(o.b);
			return 56'(r.frac ? x * y * 2 : x * y);
		end
		if (r.op == MDS_OP_SHIFT) begin
			v = r.dsp ? o.acc : 40'(o.a);
			if (!r.dsp && r.arith)
				v = 40'($signed(o.a));
			y = r.amt > 16 ? 16 : r.amt;
			if (r.left)
				return 56'(v << y);
			if (r.arith)
				return 56'($signed(v) >>> y);
			return 56'(v >> y);
		end
		x = r.wide ? {o.hi, o.a} : o.a;
		if (r.sgn == MDS_SM_SS)
			x = r.wide ? $signed({o.hi, o.a}) : $signed(o.a);
		if (r.sgn == MDS_SM_SS)
			y = $signed(o.b);
		if (r.frac)
			x = x * 32768;
		v = 40'(x / y);
		return {16'(x % y), {24{v[15]}}, v[15:0]};
	endfunction
	task automatic apb(input logic w, input logic [11:0] ad,
			input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= ad;
		pwdata_in <= wd;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n == 20)
			give_verdict(1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge core_clk_in);
	endtask
	task automatic run(input mds_req_t r, input mds_opnd_t o);
		logic [55:0] ex;
		int n;
		ex = expect_of(r, o);
		rq <= r;
		od <= o;
		go <= 1'b1;
		@(posedge core_clk_in);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (!(r.op == MDS_OP_DIV ? div_done_out === 1'b1
			: op_valid_in && !sbusy) && n < 99);
		if (n == 99)
			give_verdict(1);
		#1;
		chk(result_out, ex[39:0]);
		if (r.op == MDS_OP_DIV && !r.frac)
			chk(remainder_out, ex[55:40]);
		// Model takes the request, then nineteen divide cycles when unpaused.
		if (r.op == MDS_OP_DIV && !rndp)
			chk(n, 1 + 19);
		@(posedge core_clk_in);
	endtask
	task automatic div(input mds_sign_t s, input logic f, input logic w,
			input logic [15:0] h, input logic [15:0] a, input logic [15:0] b);
		run('{op: MDS_OP_DIV, sgn: s, frac: f, wide: w, default: '0},
			'{hi: h, a: a, b: b, default: '0});
	endtask
	initial begin
		logic [31:0] d;
		logic        e;
		mds_req_t    r;
		mds_opnd_t   o;
		void'($urandom(42));
		repeat (2) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		apb(1'b0, 12'h044, 32'h0, d, e);
		chk(d, 32'h20);
		apb(1'b1, 12'h044, 32'hffffffff, d, e);
		apb(1'b0, 12'h044, 32'h0, d, e);
		chk(d, 32'h1fff);
		apb(1'b0, 12'h100, 32'h0, d, e);
		chk({d, e}, 33'h1);
		for (int i = 0; i < 12; i++) begin
			r = '{op: MDS_OP_MUL, sgn: mds_sign_t'(i % 4), frac: i[2],
				dsp: i > 9, default: '0};
			o = 88'({$urandom, $urandom, $urandom});
			if (i == 4)
				o[87:56] = 32'h80008000;
			if (i == 11)
				apb(1'b1, 12'h044, 32'h20, d, e);
			us = i < 11;
			run(r, o);
		end
		for (int i = 0; i < 16; i++) begin
			r = '{op: MDS_OP_SHIFT, sgn: MDS_SM_SS, default: '0};
			{r.dsp, r.left, r.arith} = 3'(i);
			r.amt = i > 7 ? 5'h10 + 5'(i % 4) : 5'($urandom_range(15));
			o = 88'({$urandom, $urandom, $urandom});
			run(r, o);
		end
		div(MDS_SM_SS, 1'b0, 1'b0, 16'h0, 16'hff9c, 16'h7);
		div(MDS_SM_UU, 1'b0, 1'b0, 16'h0, 16'hff9c, 16'h7);
		rndp <= 1'b1;
		div(MDS_SM_SS, 1'b0, 1'b1, 16'hffff, 16'h8000, 16'h3);
		div(MDS_SM_UU, 1'b0, 1'b1, 16'h1, 16'h0, 16'h3);
		div(MDS_SM_SS, 1'b1, 1'b0, 16'h0, 16'he000, 16'h4000);
		apb(1'b0, 12'h064, 32'h0, d, e);
		chk(d, 32'hffffc000);
		give_verdict(0);
	end
endmodule
`default_nettype wire
